// ==== include/servo_io_pkg.sv ====
// Constants, field layouts and carrier types for the servo I/O routing block
package servo_io_pkg;

  // Widths and counts
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_IN_PINS = 8;
  localparam int NUM_OUT_PINS = 4;
  localparam int NUM_IN_FUNC = 9;
  localparam int NUM_OUT_FUNC = 9;
  localparam int SEL_W = 4;
  localparam int SEL_REG_W = 16;
  localparam int SEL_BANK_W = 64;
  localparam int ROT_W = 14;
  localparam int SPEED_W = 16;
  localparam int IRQ_W = 4;
  localparam int MON_FUNC_LSB = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_IN_SEL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_SEL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IN_SEL_C = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IN_SEL_D = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL_A = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL_B = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL_C = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL_D = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ROT_THR = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IN_MON = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OUT_MON = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h30;

  // Selector codes
  localparam logic [SEL_W-1:0] SEL_PIN_LAST = 4'h7;
  localparam logic [SEL_W-1:0] SEL_OFF = 4'h8;
  localparam logic [SEL_W-1:0] SEL_ON = 4'h9;

  // Reset values
  localparam logic [SEL_BANK_W-1:0] IN_SEL_RST =
    {16'h0008, 16'h6543, 16'h8802, 16'h1000};
  localparam logic [SEL_BANK_W-1:0] OUT_SEL_RST =
    {16'h0000, 16'h0001, 16'h0000, 16'h0000};
  localparam logic [ROT_W-1:0] ROT_THR_RST = 14'h0014;
  localparam logic [DATA_W-1:0] ROT_THR_LIMIT = 32'h0000_2710;

  // Input function indices
  localparam int IF_FWD_PROHIBIT = 0;
  localparam int IF_REV_PROHIBIT = 1;
  localparam int IF_FWD_TORQUE = 2;
  localparam int IF_REV_TORQUE = 3;
  localparam int IF_HOMING_DECEL = 4;
  localparam int IF_LATCH_1 = 5;
  localparam int IF_LATCH_2 = 6;
  localparam int IF_LATCH_3 = 7;
  localparam int IF_FORCED_STOP = 8;

  // Output function indices
  localparam int OF_POS_DONE = 0;
  localparam int OF_SPEED_MATCH = 1;
  localparam int OF_ROT_DETECT = 2;
  localparam int OF_READY = 3;
  localparam int OF_BRAKE = 4;
  localparam int OF_NEAR = 5;
  localparam int OF_WARN = 6;
  localparam int OF_FAULT = 7;
  localparam int OF_TORQUE_DET = 8;

  // Nibble position of each function's selector in its bank
  localparam int IN_NIB [NUM_IN_FUNC] = '{3, 4, 6, 7, 8, 9, 10, 11, 12};
  localparam int OUT_NIB [NUM_OUT_FUNC] = '{0, 1, 2, 3, 4, 5, 7, 8, 12};
  // Functions asserted by a closed contact
  localparam logic [NUM_IN_FUNC-1:0] IN_ACT_LOW = 9'h0FC;

  // Interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_ROT = 2;
  localparam int IRQ_FORCED_STOP_IN = 3;

  typedef struct packed {
    logic forced_stop_in;
    logic latch_in_3;
    logic latch_in_2;
    logic latch_in_1;
    logic homing_decel_switch;
    logic rev_torque_limit_in;
    logic fwd_torque_limit_in;
    logic rev_drive_prohibit;
    logic fwd_drive_prohibit;
  } in_func_type;

  typedef struct packed {
    logic [SPEED_W-1:0] motor_speed;
    logic fault;
    logic warn;
    logic torque_det;
    logic near;
    logic brake;
    logic ready;
    logic speed_match;
    logic pos_done;
  } drive_status_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [NUM_IN_PINS-1:0] s2;
    logic [NUM_IN_PINS-1:0] s1;
  } sync_type;

  typedef struct packed {
    logic [SEL_BANK_W-1:0] in_sel;
    logic [SEL_BANK_W-1:0] out_sel;
    logic [ROT_W-1:0] rot_thr;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [NUM_IN_FUNC-1:0] in_func;
    logic [NUM_OUT_FUNC-1:0] out_func;
    logic [NUM_OUT_PINS-1:0] out_pins;
    logic fault_d;
    logic warn_d;
    logic rot_d;
    logic stop;
    logic [DATA_W-1:0] rdata;
  } core_type;

  localparam core_type CORE_RST = '{
    in_sel: IN_SEL_RST,
    out_sel: OUT_SEL_RST,
    rot_thr: ROT_THR_RST,
    default: '0
  };

endpackage

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for the physical input pins
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pins
  input wire logic [servo_io_pkg::NUM_IN_PINS-1:0] pins_i,
  output logic [servo_io_pkg::NUM_IN_PINS-1:0] pins_o
);
  import servo_io_pkg::*;

  sync_type q;
  sync_type d;

  always_comb begin
    d.s1 = pins_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign pins_o = q.s2;

endmodule

// ==== rtl/servo_io_routing.sv ====
// Servo drive I/O signal routing, polarity, status outputs and registers
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module servo_io_routing (
  // Clock, reset and enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port
  input wire servo_io_pkg::reg_req_type reg_i,
  output logic [servo_io_pkg::DATA_W-1:0] rdata_o,
  // Connector pins
  input wire logic [servo_io_pkg::NUM_IN_PINS-1:0] in_pins_i,
  output logic [servo_io_pkg::NUM_OUT_PINS-1:0] out_pins_o,
  // Drive core
  input wire servo_io_pkg::drive_status_type status_i,
  input wire logic [servo_io_pkg::NUM_OUT_FUNC-1:0] mode_eval_i,
  output servo_io_pkg::in_func_type in_func_o,
  output logic stop_o,
  // Interrupt
  output logic irq_o
);
  import servo_io_pkg::*;

  core_type q;
  core_type d;
  logic [NUM_IN_PINS-1:0] pins_s;

  // Pins enter the clock domain here
  pin_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins_i(in_pins_i),
    .pins_o(pins_s)
  );

  always_comb begin
    logic [SEL_W-1:0] sel;
    logic contact;
    logic rot_now;
    logic [NUM_OUT_FUNC-1:0] ofunc;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [DATA_W-1:0] rd_data;
    logic acc;
    sel = '0;
    contact = 1'b0;
    rot_now = 1'b0;
    ofunc = '0;
    ev = '0;
    clr = '0;
    rd_data = '0;
    acc = 1'b0;
    d = q;

    // Input decode; each function reads its own field
    for (int f = 0; f < NUM_IN_FUNC; f++) begin
      sel = q.in_sel[IN_NIB[f]*SEL_W +: SEL_W];
      contact = pins_s[sel[2:0]];
      if (sel == SEL_OFF) begin
        d.in_func[f] = 1'b0;
      end else if (sel == SEL_ON) begin
        d.in_func[f] = 1'b1;
      end else if (sel <= SEL_PIN_LAST) begin
        if (IN_ACT_LOW[f]) begin
          d.in_func[f] = contact;
        end else begin
          d.in_func[f] = !contact;
        end
      end else begin
        // Codes above 9 are treated like unassigned
        d.in_func[f] = 1'b0;
      end
    end

    // Output function conditions, 1 = contact closed
    rot_now = status_i.motor_speed > {2'h0, q.rot_thr};
    ofunc[OF_POS_DONE] = status_i.pos_done;
    ofunc[OF_SPEED_MATCH] = status_i.speed_match;
    ofunc[OF_ROT_DETECT] = rot_now;
    ofunc[OF_READY] = status_i.ready;
    ofunc[OF_BRAKE] = status_i.brake;
    ofunc[OF_NEAR] = status_i.near;
    ofunc[OF_WARN] = status_i.warn;
    ofunc[OF_FAULT] = !status_i.fault;
    ofunc[OF_TORQUE_DET] = status_i.torque_det;
    d.out_func = ofunc & mode_eval_i;

    // Output pin code n drives pin n-1; code 0 leaves it unassigned
    for (int p = 0; p < NUM_OUT_PINS; p++) begin
      acc = 1'b0;
      for (int f = 0; f < NUM_OUT_FUNC; f++) begin
        sel = q.out_sel[OUT_NIB[f]*SEL_W +: SEL_W];
        if (sel == SEL_W'(p + 1)) begin
          acc = acc ^ d.out_func[f];
        end
      end
      d.out_pins[p] = acc;
    end

    // Alarm stops operation, a warning does not
    d.stop = status_i.fault;

    // Event edges
    d.fault_d = status_i.fault;
    d.warn_d = status_i.warn;
    d.rot_d = rot_now;
    ev[IRQ_FAULT] = status_i.fault & !q.fault_d;
    ev[IRQ_WARN] = status_i.warn & !q.warn_d;
    ev[IRQ_ROT] = rot_now & !q.rot_d;
    ev[IRQ_FORCED_STOP_IN] = d.in_func[IF_FORCED_STOP] & !q.in_func[IF_FORCED_STOP];

    // Register writes
    if (reg_i.wr) begin
      unique case (reg_i.addr)
        OFS_IN_SEL_A: d.in_sel[0*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_IN_SEL_B: d.in_sel[1*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_IN_SEL_C: d.in_sel[2*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_IN_SEL_D: d.in_sel[3*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_OUT_SEL_A: d.out_sel[0*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_OUT_SEL_B: d.out_sel[1*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_OUT_SEL_C: d.out_sel[2*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_OUT_SEL_D: d.out_sel[3*SEL_REG_W +: SEL_REG_W] =
          reg_i.wdata[SEL_REG_W-1:0];
        OFS_ROT_THR: begin
          // Out-of-range values are dropped, old threshold kept
          if (reg_i.wdata <= ROT_THR_LIMIT) begin
            d.rot_thr = reg_i.wdata[ROT_W-1:0];
          end
        end
        OFS_IRQ_STAT: clr = reg_i.wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: d.irq_mask = reg_i.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;

    // Register reads, data valid in the next cycle only
    if (reg_i.rd) begin
      unique case (reg_i.addr)
        OFS_IN_SEL_A: rd_data[SEL_REG_W-1:0] =
          q.in_sel[0*SEL_REG_W +: SEL_REG_W];
        OFS_IN_SEL_B: rd_data[SEL_REG_W-1:0] =
          q.in_sel[1*SEL_REG_W +: SEL_REG_W];
        OFS_IN_SEL_C: rd_data[SEL_REG_W-1:0] =
          q.in_sel[2*SEL_REG_W +: SEL_REG_W];
        OFS_IN_SEL_D: rd_data[SEL_REG_W-1:0] =
          q.in_sel[3*SEL_REG_W +: SEL_REG_W];
        OFS_OUT_SEL_A: rd_data[SEL_REG_W-1:0] =
          q.out_sel[0*SEL_REG_W +: SEL_REG_W];
        OFS_OUT_SEL_B: rd_data[SEL_REG_W-1:0] =
          q.out_sel[1*SEL_REG_W +: SEL_REG_W];
        OFS_OUT_SEL_C: rd_data[SEL_REG_W-1:0] =
          q.out_sel[2*SEL_REG_W +: SEL_REG_W];
        OFS_OUT_SEL_D: rd_data[SEL_REG_W-1:0] =
          q.out_sel[3*SEL_REG_W +: SEL_REG_W];
        OFS_ROT_THR: rd_data[ROT_W-1:0] = q.rot_thr;
        OFS_IN_MON: begin
          rd_data[NUM_IN_PINS-1:0] = pins_s;
          rd_data[MON_FUNC_LSB +: NUM_IN_FUNC] = q.in_func;
        end
        OFS_OUT_MON: begin
          rd_data[NUM_OUT_PINS-1:0] = q.out_pins;
          rd_data[MON_FUNC_LSB +: NUM_OUT_FUNC] = q.out_func;
        end
        OFS_IRQ_STAT: rd_data[IRQ_W-1:0] = q.irq_stat;
        OFS_IRQ_MASK: rd_data[IRQ_W-1:0] = q.irq_mask;
        default: ;
      endcase
    end
    d.rdata = rd_data;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= CORE_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign out_pins_o = q.out_pins;
  assign in_func_o = in_func_type'(q.in_func);
  assign stop_o = q.stop;
  assign irq_o = |(q.irq_stat & q.irq_mask);

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  logic [SEL_W-1:0] sel_fwd;
  logic [SEL_W-1:0] sel_ptq;
  logic route_fwd;
  logic route_ptq;
  logic [SEL_W-1:0] sel_dec;
  logic [DATA_W-1:0] wdata_lim;
  assign sel_fwd = q.in_sel[IN_NIB[IF_FWD_PROHIBIT]*SEL_W +: SEL_W];
  assign sel_ptq = q.in_sel[IN_NIB[IF_FWD_TORQUE]*SEL_W +: SEL_W];
  assign route_fwd = pins_s[sel_fwd[2:0]];
  assign route_ptq = pins_s[sel_ptq[2:0]];
  assign sel_dec = q.in_sel[IN_NIB[IF_HOMING_DECEL]*SEL_W +: SEL_W];
  assign wdata_lim = ROT_THR_LIMIT;

  chk_sel_forced_off: assert property (
    ce_i && sel_fwd == SEL_OFF |=> !q.in_func[IF_FWD_PROHIBIT]
  ) else $error("selector 8 did not force input inactive");

  chk_sel_forced_on: assert property (
    ce_i && sel_ptq == SEL_ON |=> q.in_func[IF_FWD_TORQUE]
  ) else $error("selector 9 did not force input active");

  chk_route_closed_on: assert property (
    !rst_i && ce_i && sel_ptq <= SEL_PIN_LAST
    |=> q.in_func[IF_FWD_TORQUE] == $past(route_ptq)
  ) else $error("active-low input not asserted by closed contact");

  chk_route_open_on: assert property (
    !rst_i && ce_i && sel_fwd <= SEL_PIN_LAST
    |=> q.in_func[IF_FWD_PROHIBIT] == !$past(route_fwd)
  ) else $error("prohibit input not asserted by open contact");

  chk_eval_gate_off: assert property (
    ce_i && !mode_eval_i[OF_POS_DONE] |=> !q.out_func[OF_POS_DONE]
  ) else $error("unevaluated output function not driven off");

  chk_fault_contact: assert property (
    !rst_i && ce_i && mode_eval_i[OF_FAULT]
    |=> q.out_func[OF_FAULT] != $past(status_i.fault)
  ) else $error("fault output polarity wrong");

  chk_warn_contact: assert property (
    !rst_i && ce_i && mode_eval_i[OF_WARN]
    |=> q.out_func[OF_WARN] == $past(status_i.warn)
  ) else $error("warning output does not follow warning");

  chk_alarm_stop: assert property (
    !rst_i && ce_i |=> stop_o == $past(status_i.fault)
  ) else $error("stop does not follow alarm alone");

  chk_rot_threshold: assert property (
    !rst_i && ce_i && mode_eval_i[OF_ROT_DETECT]
    && status_i.motor_speed > {2'h0, q.rot_thr}
    |=> q.out_func[OF_ROT_DETECT]
  ) else $error("rotation detect missing above threshold");

  chk_thr_range: assert property (
    ce_i && reg_i.wr && reg_i.addr == OFS_ROT_THR
    && reg_i.wdata > wdata_lim |=> $stable(q.rot_thr)
  ) else $error("out-of-range threshold accepted");

  chk_mon_inputs: assert property (
    ce_i && reg_i.rd && reg_i.addr == OFS_IN_MON
    |=> rdata_o[MON_FUNC_LSB +: NUM_IN_FUNC] == $past(q.in_func)
  ) else $error("input monitor read wrong");

  chk_irq_sticky: assert property (
    ce_i && q.irq_stat[IRQ_FAULT]
    && !(reg_i.wr && reg_i.addr == OFS_IRQ_STAT) |=> q.irq_stat[IRQ_FAULT]
  ) else $error("sticky fault status lost");

  chk_sync_two_stages: assert property (
    !rst_i && ce_i ##1 ce_i
    |=> pins_s == $past(in_pins_i, 2)
  ) else $error("pin synchroniser depth wrong");

  chk_shared_pin: assert property (
    !rst_i && ce_i && sel_ptq == sel_dec && sel_dec <= SEL_PIN_LAST
    |=> q.in_func[IF_FWD_TORQUE] == q.in_func[IF_HOMING_DECEL]
  ) else $error("inputs sharing a pin disagree");

  chk_code_high_off: assert property (
    !rst_i && ce_i && sel_fwd > SEL_ON
    |=> !q.in_func[IF_FWD_PROHIBIT]
  ) else $error("selector above 9 did not leave input inactive");

  chk_rot_below: assert property (
    !rst_i && ce_i && status_i.motor_speed <= {2'h0, q.rot_thr}
    |=> !q.out_func[OF_ROT_DETECT]
  ) else $error("rotation detect set at or below threshold");

  chk_thr_apply: assert property (
    !rst_i && ce_i && reg_i.wr && reg_i.addr == OFS_ROT_THR
    && reg_i.wdata <= wdata_lim
    |=> q.rot_thr == $past(reg_i.wdata[ROT_W-1:0])
  ) else $error("threshold write not applied at once");

  chk_warn_no_stop: assert property (
    !rst_i && ce_i && status_i.warn && !status_i.fault |=> !stop_o
  ) else $error("warning alone stopped operation");

  chk_out_mon: assert property (
    !rst_i && ce_i && reg_i.rd && reg_i.addr == OFS_OUT_MON
    |=> rdata_o[NUM_OUT_PINS-1:0] == $past(q.out_pins)
  ) else $error("output monitor read wrong");

  chk_rdata_idle: assert property (
    !rst_i && ce_i && !reg_i.rd |=> rdata_o == '0
  ) else $error("read data stood beyond its cycle");

  chk_warn_set_wins: assert property (
    !rst_i && ce_i && status_i.warn && !q.warn_d
    |=> q.irq_stat[IRQ_WARN]
  ) else $error("warning event lost against a clear");

  chk_forced_stop_in_event: assert property (
    !rst_i && ce_i && d.in_func[IF_FORCED_STOP]
    && !q.in_func[IF_FORCED_STOP] |=> q.irq_stat[IRQ_FORCED_STOP_IN]
  ) else $error("forced stop event not flagged");

  chk_w1c_clear: assert property (
    !rst_i && ce_i && reg_i.wr && reg_i.addr == OFS_IRQ_STAT
    && reg_i.wdata[IRQ_FAULT] && !(status_i.fault && !q.fault_d)
    |=> !q.irq_stat[IRQ_FAULT]
  ) else $error("fault status not cleared by a one");

  chk_ce_freeze: assert property (
    !rst_i && !ce_i |=> $stable(q)
  ) else $error("state moved while enable low");

endmodule

// ==== sim/field_switches.sv ====
// Field switch model that drives the connector input pins
`timescale 1ns/1ps
module field_switches (
  // Clock
  input wire logic clock_i,
  // Commanded contact states, 1 = closed
  input wire logic [servo_io_pkg::NUM_IN_PINS-1:0] pins_cmd_i,
  // Connector pins
  output logic [servo_io_pkg::NUM_IN_PINS-1:0] pins_o
);
  import servo_io_pkg::*;

  // Contacts move just after an edge of the block's clock, so the block first samples them on the next edge
  always_ff @(posedge clock_i) begin
    pins_o <= pins_cmd_i;
  end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the servo I/O routing block
`timescale 1ns/1ps
module tb_top;
  import servo_io_pkg::*;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  reg_req_type req = '0;
  drive_status_type status = '0;
  drive_status_type st = '0;
  logic [NUM_OUT_FUNC-1:0] mode_eval = '1;
  logic [NUM_OUT_FUNC-1:0] me = '1;
  logic [NUM_IN_PINS-1:0] pins_cmd = '0;
  logic [NUM_IN_PINS-1:0] pins;
  logic [DATA_W-1:0] rdata;
  logic [NUM_OUT_PINS-1:0] out_pins;
  in_func_type in_func;
  logic stop;
  logic irq;
  int fail_count = 0;
  int samples_checked = 0;

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  field_switches i_field_switches (
    .clock_i(clock_i),
    .pins_cmd_i(pins_cmd),
    .pins_o(pins)
  );

  servo_io_routing i_servo_io_routing (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce),
    .reg_i(req),
    .rdata_o(rdata),
    .in_pins_i(pins),
    .out_pins_o(out_pins),
    .status_i(status),
    .mode_eval_i(mode_eval),
    .in_func_o(in_func),
    .stop_o(stop),
    .irq_o(irq)
  );

  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expct);
    samples_checked++;
    if (seen !== expct) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expct);
    end
  endtask

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expct);
    @(posedge clock_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    check(rdata, expct);
  endtask

  // Drive status, mode and pins, then let the pin path settle
  task automatic apply(input logic [7:0] p);
    @(posedge clock_i);
    status <= st;
    mode_eval <= me;
    pins_cmd <= p;
    repeat (5) @(posedge clock_i);
    #1;
  endtask

  task automatic t_reset_values();
    logic [15:0] rst_word [8] = '{16'h1000, 16'h8802, 16'h6543, 16'h0008,
                                  16'h0000, 16'h0000, 16'h0001, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(4 * i), 32'(rst_word[i]));
    end
    rd_chk(OFS_ROT_THR, 32'h0000_0014);
  endtask

  task automatic t_input_codes();
    logic [7:0] p;
    for (int c = 0; c <= 10; c++) begin
      wr_reg(OFS_IN_SEL_A, 32'(c) << 12);
      for (int v = 0; v < 2; v++) begin
        p = (c < 8) ? (8'(v) << c) : {8{v[0]}};
        apply(p);
        check(32'(in_func.fwd_drive_prohibit),
              (c < 8) ? 32'(v == 0) : 32'(c == 9));
      end
    end
  endtask

  // Pin 3 is shared by three functions, pin 4 feeds a latch input
  task automatic t_shared_inputs();
    wr_reg(OFS_IN_SEL_B, 32'h0000_0303);
    for (int v = 0; v < 2; v++) begin
      apply((v == 1) ? 8'h18 : 8'h00);
      check(32'(in_func.rev_drive_prohibit), 32'(v == 0));
      check(32'(in_func.fwd_torque_limit_in), 32'(v));
      check(32'(in_func.homing_decel_switch), 32'(v));
      check(32'(in_func.latch_in_1), 32'(v));
    end
    rd_chk(OFS_IN_MON, 32'h0034_0018);
  endtask

  // One edge in the switch model, then two sync stages and the decode
  task automatic t_sync_delay();
    @(posedge clock_i);
    pins_cmd <= 8'h10;
    repeat (3) @(posedge clock_i);
    #1;
    check(32'(in_func.fwd_torque_limit_in), 32'h1);
    tick();
    check(32'(in_func.fwd_torque_limit_in), 32'h0);
  endtask

  task automatic t_outputs();
    st = '0;
    apply(8'h10);
    check(32'(out_pins), 32'h1);
    check(32'(stop), 32'h0);
    wr_reg(OFS_OUT_SEL_A, 32'h0000_0200);
    wr_reg(OFS_OUT_SEL_B, 32'h0000_2000);
    st.motor_speed = 16'h0015;
    apply(8'h10);
    check(32'(out_pins), 32'h3);
    st.warn = 1'b1;
    apply(8'h10);
    check(32'(out_pins), 32'h1);
    check(32'(stop), 32'h0);
    st.motor_speed = 16'h0014;
    apply(8'h10);
    check(32'(out_pins), 32'h3);
    me[OF_WARN] = 1'b0;
    apply(8'h10);
    check(32'(out_pins), 32'h1);
    me = '1;
    st.warn = 1'b0;
    wr_reg(OFS_ROT_THR, 32'h0000_0064);
    st.motor_speed = 16'h0064;
    apply(8'h10);
    check(32'(out_pins), 32'h1);
    st.motor_speed = 16'h0065;
    apply(8'h10);
    check(32'(out_pins), 32'h3);
    rd_chk(OFS_OUT_MON, 32'h0084_0003);
    wr_reg(OFS_ROT_THR, 32'h0000_2711);
    rd_chk(OFS_ROT_THR, 32'h0000_0064);
    wr_reg(OFS_ROT_THR, 32'h0000_2710);
    rd_chk(OFS_ROT_THR, 32'h0000_2710);
    st.fault = 1'b1;
    apply(8'h10);
    check(32'(out_pins), 32'h0);
    check(32'(stop), 32'h1);
  endtask

  task automatic t_irq();
    rd_chk(OFS_IRQ_STAT, 32'h0000_0007);
    check(32'(irq), 32'h0);
    wr_reg(OFS_IRQ_MASK, 32'h0000_0001);
    tick();
    check(32'(irq), 32'h1);
    wr_reg(OFS_IRQ_STAT, 32'h0000_0001);
    tick();
    check(32'(irq), 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0006);
    rd_chk(8'h40, 32'h0000_0000);
    wr_reg(OFS_IRQ_STAT, 32'h0000_0006);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
    // Warning rises in the cycle its bit is cleared; the set must win
    st.warn = 1'b1;
    @(posedge clock_i);
    status <= st;
    req.wr <= 1'b1;
    req.addr <= OFS_IRQ_STAT;
    req.wdata <= 32'h0000_0002;
    @(posedge clock_i);
    req.wr <= 1'b0;
    rd_chk(OFS_IRQ_STAT, 32'h0000_0002);
    wr_reg(OFS_IN_SEL_D, 32'h0000_0009);
    rd_chk(OFS_IRQ_STAT, 32'h0000_000A);
    check(32'(in_func.forced_stop_in), 32'h1);
  endtask

  // A low enable freezes every register, read strobes included
  task automatic t_clock_enable();
    st.fault = 1'b0;
    st.warn = 1'b0;
    @(posedge clock_i);
    ce <= 1'b0;
    apply(8'h10);
    check(32'(out_pins), 32'h2);
    check(32'(stop), 32'h1);
    rd_chk(OFS_ROT_THR, 32'h0000_0000);
    @(posedge clock_i);
    ce <= 1'b1;
    tick();
    check(32'(out_pins), 32'h1);
    check(32'(stop), 32'h0);
  endtask

  // Reset again in mid-run restores every register
  task automatic t_mid_reset();
    @(posedge clock_i);
    rst_i <= 1'b1;
    tick();
    check(32'(out_pins), 32'h0);
    check(32'(in_func), 32'h0);
    check(32'(stop), 32'h0);
    check(32'(irq), 32'h0);
    check(rdata, 32'h0);
    @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset_values();
    apply(8'h10);
    check(32'(out_pins), 32'h1);
  endtask

  // Guard against a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_input_codes();
    t_shared_inputs();
    t_sync_delay();
    t_outputs();
    t_irq();
    t_clock_enable();
    t_mid_reset();
    end_sim();
  end
endmodule
